// ### hdl/p4g_pkg.sv
package p4g_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] P4G_OFS_DATA    = 4'h0;
  localparam logic [3:0] P4G_OFS_DIR     = 4'h4;
  localparam logic [3:0] P4G_OFS_PULL    = 4'h8;
  localparam logic [3:0] P4G_OFS_AIDIS   = 4'hC;
  localparam int         P4G_ADDR_W      = 4;
  localparam int         P4G_PINS        = 8;
  localparam int         P4G_ANA_PINS    = 4;
  localparam logic [7:0] P4G_DATA_RST    = 8'h00;
  localparam logic [7:0] P4G_DIR_RST     = 8'h00;
  localparam logic [7:0] P4G_PULL_RST    = 8'h00;
  localparam logic [3:0] P4G_AIDIS_RST   = 4'h0;
  localparam logic [7:0] P4G_WAKE_MASK   = 8'hA0;
  localparam logic [1:0] P4G_RESP_OKAY   = 2'h0;
  localparam logic [1:0] P4G_RESP_SLVERR = 2'h2;
endpackage : p4g_pkg

// ### hdl/p4g_sync.sv
`timescale 1ns/1ns
module p4g_sync
  import p4g_pkg::*;
(
  input  wire logic       mclk_i,  // System clock
  input  wire logic       rstn_i,  // Sync reset, active low
  input  wire logic [7:0] d_i,     // Asynchronous pin levels
  output logic      [7:0] q_o      // Synchronised levels
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule : p4g_sync

// ### hdl/p4g_port.sv
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Direction bit 1 makes the pin a port output, 0 a port input.
// - Output pins drive their data latch bit level.
// - Data writes always update latch; input pins do not show it.
// - Output-direction pins without a peripheral claim read back the latch value.
// - Input pins read pin level; read-modify-write reads return the latch.
// - Peripheral output claims pin; reads give pin level, RMW reads latch.
// - Peripheral input pins read pin level; RMW reads return latch.
// - Analog-disable 0 blocks digital input on pins 0 to 3.
// - Reset clears all direction bits, making every pin an input.
// - Reset clears analog-disable bits, digital input blocked on analog pins.
// - Standby with pin-state bit set: pins float, inputs forced low.
// - In that standby, pins 5 and 7 stay open if wake enabled.
// - Standby with pin-state bit clear keeps configuration and output level.
// - Pull-up bit 1 connects the pull-up, 0 disconnects it.
// - A pin driving low always has its pull-up disconnected.
// - Register bit n controls pin n; analog-disable bits 0-3 map pins 0-3.
module p4g_port
  import p4g_pkg::*;
(
  input  wire logic        mclk_i,          // System clock, 20 MHz
  input  wire logic        rstn_i,          // Sync reset, active low
  input  wire logic [3:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [3:0]  s_axi_araddr,    // Read address
  input  wire logic [2:0]  s_axi_arprot,    // Read prot, bit0 marks RMW read
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        rmw_read_i,      // Current read is from an RMW op
  input  wire logic [7:0]  pin_i,           // Pad input levels
  output logic [7:0]       pin_o,           // Pad output levels
  output logic [7:0]       pin_oe_o,        // Pad output enables
  output logic [7:0]       pullup_en_o,     // Pull-up connect per pin
  output logic [3:0]       analog_en_o,     // Analog path enable, pins 0-3
  input  wire logic [7:0]  periph_oe_i,     // Peripheral output enables
  input  wire logic [7:0]  periph_out_i,    // Peripheral output levels
  output logic [7:0]       periph_in_o,     // Gated inputs to peripherals
  input  wire logic        standby_i,       // Stop or watch mode active
  input  wire logic        standby_pin_state_bit_i, // Float pins in standby
  input  wire logic [7:0]  wake_en_i        // Interrupt input enable per pin
);
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] pull_q;
  logic [3:0] aidis_q;
  logic [7:0] pin_sync;
  logic [7:0] pin_gated;
  logic [7:0] drv_oe;
  logic [7:0] drv_lvl;
  logic       float_all;
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [7:0]  pad_rd;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] st);
    merge8 = st[0] ? wd[7:0] : old;
  endfunction : merge8

  p4g_sync u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (pin_i),
    .q_o    (pin_sync)
  );

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go         = aw_hold_q && w_hold_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= P4G_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q[3:2] <= P4G_OFS_AIDIS[3:2]) ? P4G_RESP_OKAY
                                                              : P4G_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register file; latch always updates whatever the direction
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      data_q <= P4G_DATA_RST;
    end else if (wr_go && aw_addr_q == P4G_OFS_DATA) begin
      data_q <= merge8(data_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dir_q <= P4G_DIR_RST;
    end else if (wr_go && aw_addr_q == P4G_OFS_DIR) begin
      dir_q <= merge8(dir_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pull_q <= P4G_PULL_RST;
    end else if (wr_go && aw_addr_q == P4G_OFS_PULL) begin
      pull_q <= merge8(pull_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      aidis_q <= P4G_AIDIS_RST;
    end else if (wr_go && aw_addr_q == P4G_OFS_AIDIS && w_strb_q[0]) begin
      aidis_q <= w_data_q[P4G_ANA_PINS-1:0];
    end
  end

  // Pad drive: peripheral claim wins over port output
  assign float_all = standby_i && standby_pin_state_bit_i;
  always_comb begin
    for (int i = 0; i < P4G_PINS; i++) begin
      drv_oe[i]  = periph_oe_i[i] | dir_q[i];
      drv_lvl[i] = periph_oe_i[i] ? periph_out_i[i] : data_q[i];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pin_oe_o    <= 8'h00;
      pin_o       <= 8'h00;
      pullup_en_o <= 8'h00;
    end else begin
      pin_oe_o    <= float_all ? 8'h00 : drv_oe;
      pin_o       <= drv_lvl;
      // Pull-up off on low drive, and while floated in standby
      pullup_en_o <= float_all ? 8'h00 : (pull_q & ~(drv_oe & ~drv_lvl));
    end
  end

  assign analog_en_o = ~aidis_q;

  // Input gating: analog-shared pins need their disable bit set
  always_comb begin
    for (int i = 0; i < P4G_PINS; i++) begin
      pin_gated[i] = pin_sync[i];
      if (i < P4G_ANA_PINS && !aidis_q[i % P4G_ANA_PINS]) begin
        pin_gated[i] = 1'b0;
      end
      if (float_all && !(P4G_WAKE_MASK[i] && wake_en_i[i])) begin
        pin_gated[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      periph_in_o <= 8'h00;
    end else begin
      periph_in_o <= pin_gated;
    end
  end

  // Read path: output pins not claimed by a peripheral read latch, others read pad unless RMW
  always_comb begin
    for (int i = 0; i < P4G_PINS; i++) begin
      pad_rd[i] = (dir_q[i] && !periph_oe_i[i]) ? data_q[i] : pin_gated[i];
    end
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      P4G_OFS_DATA:  rd_val[7:0] = (rmw_read_i || s_axi_arprot[0]) ? data_q : pad_rd;
      P4G_OFS_DIR:   rd_val[7:0] = dir_q;
      P4G_OFS_PULL:  rd_val[7:0] = pull_q;
      P4G_OFS_AIDIS: rd_val[3:0] = aidis_q;
      default:       rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= P4G_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? P4G_RESP_OKAY : P4G_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on pad drive, standby gating and the read path
  a_float_pins: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    float_all
    |=> pin_oe_o == 8'h00)
    else $error("pins not floated in standby");

  a_drive_dir: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (!float_all && dir_q[0] && !periph_oe_i[0])
    |=> (pin_oe_o[0] && pin_o[0] == $past(data_q[0])))
    else $error("output pin not driving latch");

  a_input_hiz: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (!dir_q[3] && !periph_oe_i[3])
    |=> !pin_oe_o[3])
    else $error("input pin driven");

  a_pull_low: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (drv_oe[2] && !drv_lvl[2])
    |=> !pullup_en_o[2])
    else $error("pull-up on a low pin");

  a_pull_on: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (!float_all && pull_q[6] && !drv_oe[6])
    |=> pullup_en_o[6])
    else $error("pull-up not connected");

  a_analog_block: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !aidis_q[1]
    |-> (!pin_gated[1] && analog_en_o[1]))
    else $error("digital input not blocked");

  a_wake_open: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (float_all && wake_en_i[7])
    |-> pin_gated[7] == pin_sync[7])
    else $error("wake pin blocked");

  a_wake_mask: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    float_all
    |-> (pin_gated & ~P4G_WAKE_MASK) == 8'h00)
    else $error("non-wake pin open in standby");

  a_float_pull: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    float_all
    |=> pullup_en_o == 8'h00)
    else $error("pull-up on while floated");

  a_hold_level: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (!float_all && drv_oe[1])
    |=> (pin_oe_o[1] && pin_o[1] == $past(drv_lvl[1])))
    else $error("drive not held in standby");

  a_periph_claim: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    periph_oe_i[4]
    |=> pin_o[4] == $past(periph_out_i[4]))
    else $error("peripheral level not on pin");

  a_latch_write: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wr_go && aw_addr_q == P4G_OFS_DATA && w_strb_q[0])
    |=> data_q == $past(w_data_q[7:0]))
    else $error("latch not updated by write");

  a_read_latch: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == P4G_OFS_DATA && !rmw_read_i
     && !s_axi_arprot[0] && dir_q[6] && !periph_oe_i[6])
    |=> s_axi_rdata[6] == $past(data_q[6]))
    else $error("output pin read not latch");

  a_rmw_latch: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == P4G_OFS_DATA && rmw_read_i)
    |=> s_axi_rdata[7:0] == $past(data_q))
    else $error("RMW read not latch");

  a_aidis_upper: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == P4G_OFS_AIDIS)
    |=> s_axi_rdata[7:4] == 4'h0)
    else $error("upper disable bits not zero");

  a_reset_dir: assert property (
    @(posedge mclk_i)
    !rstn_i
    |=> (dir_q == 8'h00 && aidis_q == 4'h0))
    else $error("reset did not clear direction");

  a_reset_pins: assert property (
    @(posedge mclk_i)
    !rstn_i
    |=> pin_oe_o == 8'h00)
    else $error("reset left a pin driven");
endmodule : p4g_port

// ### testbench/p4g_pad_model.sv
`timescale 1ns/1ns
module p4g_pad_model (
  input  wire logic       mclk_i,   // System clock
  input  wire logic [7:0] pin_i,    // Block pad levels
  input  wire logic [7:0] oe_i,     // Block drives pad
  input  wire logic [7:0] pu_i,     // Pull-up connected
  input  wire logic [7:0] ext_en_i, // Board drives pad
  input  wire logic [7:0] ext_i,    // Board level
  output logic      [7:0] pad_o     // Resolved pad level
);
  logic [7:0] last_q = 8'h00;
  always_ff @(posedge mclk_i) begin
    last_q <= pad_o;
  end
  // Floating pads wander so stale levels never look valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) pad_o[i] = pin_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_i[i];
      else if (pu_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = ~last_q[i];
    end
  end
endmodule : p4g_pad_model

// ### testbench/port4_gpio_analog_shared_tb_top.sv
`timescale 1ns/1ns
module port4_gpio_analog_shared_tb_top;
  import p4g_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, rmw = 0;
  logic sb = 0, standby_pin_state_bit = 0, awr, wr_, bv, arr, rv;
  logic [3:0] awa = 0, ara = 0, ws = 0, aen;
  logic [2:0] apr = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp;
  logic [7:0] pad, po, poe, pu, pin_in, poe_p = 0, pout_p = 0, wk = 0, een = 0, ev = 0;
  int fails = 0, total_checks = 0;
  always #25 clk = ~clk;
  p4g_port dut (.mclk_i(clk), .rstn_i(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arprot(apr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .rmw_read_i(rmw), .pin_i(pad), .pin_o(po), .pin_oe_o(poe), .pullup_en_o(pu),
    .analog_en_o(aen), .periph_oe_i(poe_p), .periph_out_i(pout_p),
    .periph_in_o(pin_in), .standby_i(sb), .standby_pin_state_bit_i(standby_pin_state_bit), .wake_en_i(wk));
  p4g_pad_model pads (.mclk_i(clk), .pin_i(po), .oe_i(poe), .pu_i(pu), .ext_en_i(een),
    .ext_i(ev), .pad_o(pad));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic stop_hung;
    $display("mismatch bus wait expected answer seen none");
    fails++;
    tally_and_finish();
  endtask : stop_hung
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    bit done;
    n = 0;
    done = 0;
    awa <= a; wd <= {24'h0, d}; ws <= 4'hF; awv <= 1; wv <= 1; br <= 1;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
      if (bv) done = 1;
      if (++n > 50) stop_hung();
    end
    br <= 0;
    chk("bresp", P4G_RESP_OKAY, bresp);
    @(posedge clk);
  endtask : wr
  task automatic rdc(input string nm, input logic [3:0] a, input logic [1:0] m,
                     input logic [7:0] e, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    ara <= a; apr <= {2'b0, m[0]}; rmw <= m[1]; arv <= 1; rr <= 1;
    while (!done) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) done = 1;
      if (++n > 50) stop_hung();
    end
    rr <= 0; rmw <= 0;
    chk({nm, " resp"}, er, rresp);
    if (er === P4G_RESP_OKAY) chk(nm, e, rd);
    @(posedge clk);
  endtask : rdc
  task automatic t_reset;
    rdc("dir", P4G_OFS_DIR, 0, 8'h00, P4G_RESP_OKAY);
    rdc("aidis", P4G_OFS_AIDIS, 0, 8'h00, P4G_RESP_OKAY);
    chk("analog_en", 4'hF, aen);
    chk("oe reset", 8'h00, poe);
    rdc("unaligned", 4'h2, 0, 8'h00, P4G_RESP_SLVERR);
  endtask : t_reset
  task automatic t_out;
    een <= 8'hFF; ev <= 8'h5A;
    wr(P4G_OFS_DIR, 8'hFF);
    wr(P4G_OFS_DATA, 8'hA5);
    wr(P4G_OFS_PULL, 8'hFF);
    wt(4);
    chk("oe out", 8'hFF, poe);
    chk("pin out", 8'hA5, po);
    chk("pull low off", 8'hA5, pu);
    rdc("data out", P4G_OFS_DATA, 0, 8'hA5, P4G_RESP_OKAY);
  endtask : t_out
  task automatic t_in;
    ev <= 8'h3C;
    wr(P4G_OFS_DIR, 8'h00);
    wr(P4G_OFS_AIDIS, 8'hFF);
    wr(P4G_OFS_DATA, 8'h0F);
    wt(4);
    chk("oe in", 8'h00, poe);
    chk("pull in", 8'hFF, pu);
    chk("periph in", 8'h3C, pin_in);
    rdc("aidis hi", P4G_OFS_AIDIS, 0, 8'h0F, P4G_RESP_OKAY);
    rdc("data in", P4G_OFS_DATA, 0, 8'h3C, P4G_RESP_OKAY);
    rdc("rmw prot", P4G_OFS_DATA, 1, 8'h0F, P4G_RESP_OKAY);
    rdc("rmw line", P4G_OFS_DATA, 2, 8'h0F, P4G_RESP_OKAY);
    wr(P4G_OFS_PULL, 8'h00);
    wr(P4G_OFS_AIDIS, 8'h00);
    wt(4);
    chk("analog on", 4'hF, aen);
    chk("pull none", 8'h00, pu);
    rdc("data ana", P4G_OFS_DATA, 0, 8'h30, P4G_RESP_OKAY);
  endtask : t_in
  task automatic t_periph;
    wr(P4G_OFS_DIR, 8'hFF);
    wr(P4G_OFS_DATA, 8'h00);
    poe_p <= 8'h10; pout_p <= 8'h10;
    wt(4);
    chk("pin periph", 8'h10, po);
    rdc("data periph", P4G_OFS_DATA, 0, 8'h10, P4G_RESP_OKAY);
    rdc("rmw periph", P4G_OFS_DATA, 1, 8'h00, P4G_RESP_OKAY);
    poe_p <= 8'h00; pout_p <= 8'h00;
  endtask : t_periph
  task automatic t_standby;
    ev <= 8'hFF;
    wr(P4G_OFS_DATA, 8'h0F);
    wr(P4G_OFS_AIDIS, 8'h0F);
    sb <= 1;
    wt(4);
    chk("hold oe", 8'hFF, poe);
    chk("hold pin", 8'h0F, po);
    standby_pin_state_bit <= 1; een <= 8'h00;
    wt(4);
    chk("float oe", 8'h00, poe);
    chk("float in", 8'h00, pin_in);
    wk <= 8'hFF; een <= 8'hFF;
    wt(4);
    chk("wake in", 8'hA0, pin_in);
    sb <= 0; standby_pin_state_bit <= 0; wk <= 8'h00;
    wt(4);
    chk("resume oe", 8'hFF, poe);
  endtask : t_standby
  initial begin
    wt(8);
    rstn <= 1;
    @(posedge clk);
    t_reset();
    t_out();
    t_in();
    t_periph();
    t_standby();
    tally_and_finish();
  end
endmodule : port4_gpio_analog_shared_tb_top
